/* pkg/mhp_pkg.sv */
package mhp_pkg;

  // System clock and the line rates derived from it
  localparam int CLK_HZ = 200_000_000;
  localparam int BIT_RATE_HZ = 1200;
  localparam int BAUD_MULT = 16;

  // Half periods in system clock cycles, rounded down
  localparam int BIT_HALF_CYC = CLK_HZ / (2 * BIT_RATE_HZ);
  localparam int BAUD_HALF_CYC = CLK_HZ / (2 * BAUD_MULT * BIT_RATE_HZ);

  // Register width and select width
  localparam int REG_W = 8;
  localparam int SEL_W = 2;

  // Register indices as seen on the select lines
  localparam logic [1:0] REG_CTRL_FIRST = 2'h0;
  localparam logic [1:0] REG_CTRL_SECOND = 2'h1;
  localparam logic [1:0] REG_DETECT = 2'h2;
  localparam logic [1:0] REG_TONE = 2'h3;

  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;

  // Field positions
  localparam int CTL1_ASYNC_BIT = 5;
  localparam int CTL2_TXMODE_LSB = 0;
  localparam int CTL2_CLKOUT_BAUD_BIT = 7;

  // Transmit bit clock source
  typedef enum logic [1:0] {
    TXM_INTERNAL,
    TXM_EXTERNAL,
    TXM_SLAVE,
    TXM_SPARE
  } mhp_txmode_e;

  // Synchroniser bit layout
  localparam int SY_W = 20;
  localparam int SY_RST = 19;
  localparam int SY_SMODE = 18;
  localparam int SY_ALE = 17;
  localparam int SY_CS = 16;
  localparam int SY_RD = 15;
  localparam int SY_WR = 14;
  localparam int SY_BUS = 6;
  localparam int SY_SEL = 4;
  localparam int SY_SDI = 3;
  localparam int SY_EXT = 2;
  localparam int SY_TXD = 1;
  localparam int SY_BIAS = 0;
  // Idle-high pins start high so that no edge is seen at release
  localparam logic [19:0] SY_INIT = 20'h1c005;

endpackage : mhp_pkg

/* pkg/mhp_clk_if.sv */
interface mhp_clk_if;
  logic enable;
  logic align;
  logic level;
  logic rise;
  logic fall;

  modport gen (
    input enable,
    input align,
    output level,
    output rise,
    output fall
  );

  modport ctl (
    output enable,
    output align,
    input level,
    input rise,
    input fall
  );
endinterface : mhp_clk_if

/* src/mhp_sync.sv */
module mhp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic [WIDTH-1:0] d, // Asynchronous inputs
  output logic [WIDTH-1:0] q // Synchronised outputs
);

  logic [WIDTH-1:0] meta_q;

  // Two flops; the first is read by the second only
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : mhp_sync

/* src/mhp_bitclk.sv */
module mhp_bitclk #(
  parameter int HALF_CYC = 2
) (
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Async reset, active low
  mhp_clk_if.gen ck // Generated clock and its edge pulses
);

  localparam int CNT_W = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;

  logic [CNT_W-1:0] cnt_q;

  // Square wave; align forces the level high and restarts the count to lock phase to a reference
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
      ck.level <= 1'b0;
      ck.rise <= 1'b0;
      ck.fall <= 1'b0;
    end else if (!ck.enable) begin
      cnt_q <= '0;
      ck.level <= 1'b0;
      ck.rise <= 1'b0;
      ck.fall <= ck.level;
    end else if (ck.align) begin
      cnt_q <= '0;
      ck.level <= 1'b1;
      ck.rise <= ~ck.level;
      ck.fall <= 1'b0;
    end else if (cnt_q == CNT_W'(HALF_CYC - 1)) begin
      cnt_q <= '0;
      ck.level <= ~ck.level;
      ck.rise <= ~ck.level;
      ck.fall <= ck.level;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
      ck.rise <= 1'b0;
      ck.fall <= 1'b0;
    end
  end

endmodule : mhp_bitclk

/* src/mhp_top.sv */
// Function
// - Latch register address at latch strobe fall
// - Latch chip select at latch strobe fall
// - Bus undriven unless chip select low
// - Read strobe and select drive addressed register
// - Store bus data at write strobe rise
// - Interrupt low on detect, released by read/reset
// - Reset pin clears registers, selects crystal clock
// - Clock output crystal or sixteen times bit rate
// - Serial bits move on clock falls, direction by read
// - Serial read shifts eight bits, low first
// - Serial write strobe rise stores shifted byte
// - External timing phase-locks transmit bit clock
// - Receive data changes on receive clock falls
// - Receive bit clock runs only with carrier
// - Transmit clock internal, external-locked or slave
// - Bias pin grounded selects power down
// - Four byte registers, detect register read-only
module mhp_top
  import mhp_pkg::*;
#(
  parameter int BIT_HALF = BIT_HALF_CYC,
  parameter int BAUD_HALF = BAUD_HALF_CYC
) (
  input wire logic clk_sys, // System clock, 200 MHz
  input wire logic reset_n, // Async reset, active low
  input wire logic device_reset, // Reset pin, active high
  input wire logic serial_mode, // High selects the serial command bus
  input wire logic ale, // Address latch strobe
  input wire logic cs_n, // Chip select, active low
  input wire logic rd_n, // Read strobe, active low
  input wire logic wr_n, // Write strobe, active low
  input wire logic [7:0] bus_in, // Multiplexed bus, input side
  output logic [7:0] bus_out, // Multiplexed bus, output side
  output logic bus_oe, // Multiplexed bus drive enable
  input wire logic [1:0] register_select, // Serial register select
  input wire logic ser_data_in, // Serial data pin, input side
  output logic ser_data_out, // Serial data pin, output side
  output logic ser_data_oe, // Serial data pin drive enable
  input wire logic external_timing_clock, // Serial clock and timing reference
  input wire logic [7:0] detect_in, // Detect events from modem core
  output logic int_n, // Interrupt, active low
  output logic clk_out, // Crystal or baud clock output
  input wire logic carrier_present, // Carrier detected by modem core
  input wire logic rx_bit_in, // Received bit from demodulator
  output logic receive_bit_clock, // Receive bit clock output
  output logic rx_data_out, // Received data output
  output logic rx_bit_taken, // Pulse: demodulator bit consumed
  input wire logic tx_data_in, // Transmit data from terminal
  output logic transmit_bit_clock, // Transmit bit clock output
  output logic tx_bit_out, // Transmit bit to modulator
  output logic tx_bit_valid, // Pulse: synchronous bit sampled
  input wire logic bias_current_set, // Bias pin level, low when grounded
  output logic power_down, // Power down request
  output logic [7:0] ctrl_first_out, // First control register
  output logic [7:0] ctrl_second_out, // Second control register
  output logic [7:0] tone_select_out // Tone selection register
);

  // Synchronised pins
  logic [SY_W-1:0] sy;
  logic [SY_W-1:0] sy_p_q;

  // Every host, serial, terminal and bias pin passes two flops; carrier_present, detect_in and rx_bit_in are read directly
  mhp_sync #(
    .WIDTH(SY_W),
    .INIT(SY_INIT)
  ) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .d({device_reset, serial_mode, ale, cs_n, rd_n, wr_n, bus_in, register_select,
        ser_data_in, external_timing_clock, tx_data_in, bias_current_set}),
    .q(sy)
  );

  // Previous synchronised values for edge detection
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sy_p_q <= SY_INIT;
    end else begin
      sy_p_q <= sy;
    end
  end

  logic dev_rst;
  logic ser_md;
  logic [7:0] bus_s;
  logic [1:0] sel_s;
  logic ale_fall;
  logic rd_fall;
  logic rd_rise;
  logic wr_rise;
  logic ext_fall;
  logic ext_rise;

  assign dev_rst = sy[SY_RST];
  assign ser_md = sy[SY_SMODE];
  assign bus_s = sy[SY_BUS +: 8];
  assign sel_s = sy[SY_SEL +: 2];
  assign ale_fall = sy_p_q[SY_ALE] & ~sy[SY_ALE];
  assign rd_fall = sy_p_q[SY_RD] & ~sy[SY_RD];
  assign rd_rise = ~sy_p_q[SY_RD] & sy[SY_RD];
  assign wr_rise = ~sy_p_q[SY_WR] & sy[SY_WR];
  assign ext_fall = sy_p_q[SY_EXT] & ~sy[SY_EXT];
  assign ext_rise = ~sy_p_q[SY_EXT] & sy[SY_EXT];

  // Register file
  logic [7:0] cr_first_q;
  logic [7:0] cr_second_q;
  logic [7:0] tone_q;
  logic [7:0] det_q;

  function automatic logic [7:0] reg_mux(input logic [1:0] idx, input logic [7:0] c0,
                                         input logic [7:0] c1, input logic [7:0] dt,
                                         input logic [7:0] tn);
    logic [7:0] v;
    v = REG_RESET;
    if (idx == REG_CTRL_FIRST) begin
      v = c0;
    end else if (idx == REG_CTRL_SECOND) begin
      v = c1;
    end else if (idx == REG_DETECT) begin
      v = dt;
    end else begin
      v = tn;
    end
    return v;
  endfunction : reg_mux

  // Address and select latch, held for the access that follows
  logic [1:0] addr_q;
  logic cs_lat_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      addr_q <= REG_CTRL_FIRST;
      cs_lat_q <= 1'b0;
    end else if (ale_fall) begin
      addr_q <= {bus_s[0], bus_s[1]};
      cs_lat_q <= ~sy[SY_CS];
    end
  end

  // Parallel read is live only while latched and present select are both low
  logic par_rd;
  logic par_sel;
  assign par_sel = ~ser_md & cs_lat_q & ~sy[SY_CS];
  assign par_rd = par_sel & ~sy[SY_RD];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bus_out <= 8'h00;
      bus_oe <= 1'b0;
    end else begin
      bus_oe <= par_rd;
      if (par_rd) begin
        bus_out <= reg_mux(addr_q, cr_first_q, cr_second_q, det_q, tone_q);
      end
    end
  end

  // Bus value while the write strobe is low; hold time is shorter than sync delay
  logic [7:0] par_data_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      par_data_q <= 8'h00;
    end else if (!sy[SY_WR]) begin
      par_data_q <= bus_s;
    end
  end

  // Serial command bus shift registers
  logic [7:0] ser_out_sh_q;
  logic [7:0] ser_in_sh_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ser_out_sh_q <= 8'h00;
      ser_data_out <= 1'b0;
    end else if (ser_md && rd_fall) begin
      ser_out_sh_q <= reg_mux(sel_s, cr_first_q, cr_second_q, det_q, tone_q);
    end else if (ser_md && !sy[SY_RD] && ext_fall) begin
      ser_data_out <= ser_out_sh_q[0];
      ser_out_sh_q <= {1'b0, ser_out_sh_q[7:1]};
    end
  end

  // Read strobe low turns the data pin into an output
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ser_data_oe <= 1'b0;
    end else begin
      ser_data_oe <= ser_md & ~sy[SY_RD];
    end
  end

  // Input shift, low bit first, while read strobe is high
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ser_in_sh_q <= 8'h00;
    end else if (ser_md && sy[SY_RD] && ext_fall) begin
      ser_in_sh_q <= {sy[SY_SDI], ser_in_sh_q[7:1]};
    end
  end

  // Write request from either bus
  logic wr_go;
  logic [1:0] wr_idx;
  logic [7:0] wr_data;

  always_comb begin
    wr_go = 1'b0;
    wr_idx = addr_q;
    wr_data = par_data_q;
    if (ser_md) begin
      wr_go = wr_rise;
      wr_idx = sel_s;
      wr_data = ser_in_sh_q;
    end else begin
      wr_go = wr_rise & par_sel;
    end
  end

  // Writable registers; detect register ignores writes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cr_first_q <= REG_RESET;
      cr_second_q <= REG_RESET;
      tone_q <= REG_RESET;
    end else if (dev_rst) begin
      cr_first_q <= REG_RESET;
      cr_second_q <= REG_RESET;
      tone_q <= REG_RESET;
    end else if (wr_go) begin
      if (wr_idx == REG_CTRL_FIRST) begin
        cr_first_q <= wr_data;
      end else if (wr_idx == REG_CTRL_SECOND) begin
        cr_second_q <= wr_data;
      end else if (wr_idx == REG_TONE) begin
        tone_q <= wr_data;
      end
    end
  end

  // Track a read of the detect register; clear on the strobe's release
  logic rd_act;
  logic [1:0] rd_idx;
  logic rd_det_q;
  logic rd_clr;
  assign rd_act = ser_md ? ~sy[SY_RD] : par_rd;
  assign rd_idx = ser_md ? sel_s : addr_q;
  assign rd_clr = rd_rise & rd_det_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_det_q <= 1'b0;
    end else if (rd_rise) begin
      rd_det_q <= 1'b0;
    end else if (rd_act && rd_idx == REG_DETECT) begin
      rd_det_q <= 1'b1;
    end
  end

  // Sticky detect bits; a new event wins over the read clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      det_q <= REG_RESET;
    end else if (dev_rst) begin
      det_q <= REG_RESET;
    end else begin
      det_q <= (rd_clr ? REG_RESET : det_q) | detect_in;
    end
  end

  // Interrupt follows the sticky bits, one flop late
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      int_n <= 1'b1;
    end else begin
      int_n <= ~(|det_q) | dev_rst | rd_clr;
    end
  end

  // Clock generators
  mhp_clk_if tx_ck ();
  mhp_clk_if rx_ck ();
  mhp_clk_if baud_ck ();

  mhp_bitclk #(.HALF_CYC(BIT_HALF)) u_txgen (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .ck(tx_ck)
  );

  mhp_bitclk #(.HALF_CYC(BIT_HALF)) u_rxgen (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .ck(rx_ck)
  );

  mhp_bitclk #(.HALF_CYC(BAUD_HALF)) u_baudgen (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .ck(baud_ck)
  );

  mhp_txmode_e tx_mode;
  logic sync_md;
  assign tx_mode = mhp_txmode_e'(cr_second_q[CTL2_TXMODE_LSB +: 2]);
  assign sync_md = ~cr_first_q[CTL1_ASYNC_BIT];

  // Transmit clock free-runs; in synchronous external mode, rises of the external clock re-phase it
  assign tx_ck.enable = 1'b1;
  assign tx_ck.align = sync_md & (tx_mode == TXM_EXTERNAL) & ext_rise;
  // Receive clock stops when the carrier drops
  assign rx_ck.enable = carrier_present & ~dev_rst;
  assign rx_ck.align = 1'b0;
  assign baud_ck.enable = 1'b1;
  assign baud_ck.align = 1'b0;

  // Slave mode borrows the receive clock for transmit timing
  logic tx_lvl;
  logic tx_rise;

  always_comb begin
    tx_lvl = tx_ck.level;
    tx_rise = tx_ck.rise;
    case (tx_mode)
      TXM_SLAVE: begin
        tx_lvl = rx_ck.level;
        tx_rise = rx_ck.rise;
      end
      default: begin
        tx_lvl = tx_ck.level;
        tx_rise = tx_ck.rise;
      end
    endcase
  end

  // Transmit clock pin and data sampling at its rising edge in synchronous mode; in asynchronous mode data follows the pin
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      transmit_bit_clock <= 1'b0;
      tx_bit_out <= 1'b1;
      tx_bit_valid <= 1'b0;
    end else begin
      transmit_bit_clock <= tx_lvl;
      tx_bit_valid <= sync_md & tx_rise;
      if (!sync_md) begin
        tx_bit_out <= sy[SY_TXD];
      end else if (tx_rise) begin
        tx_bit_out <= sy[SY_TXD];
      end
    end
  end

  // Receive data moves with the receive clock's fall, valid at its rise
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      receive_bit_clock <= 1'b0;
      rx_data_out <= 1'b1;
      rx_bit_taken <= 1'b0;
    end else begin
      receive_bit_clock <= rx_ck.level;
      rx_bit_taken <= rx_ck.fall;
      if (rx_ck.fall) begin
        rx_data_out <= rx_bit_in;
      end
    end
  end

  // Crystal path is half the system clock, the fastest a flop can carry
  logic xtal_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      xtal_q <= 1'b0;
      clk_out <= 1'b0;
    end else begin
      xtal_q <= ~xtal_q;
      clk_out <= cr_second_q[CTL2_CLKOUT_BAUD_BIT] ? baud_ck.level : xtal_q;
    end
  end

  // Power down and register copies for the modem core
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      power_down <= 1'b0;
      ctrl_first_out <= REG_RESET;
      ctrl_second_out <= REG_RESET;
      tone_select_out <= REG_RESET;
    end else begin
      power_down <= ~sy[SY_BIAS];
      ctrl_first_out <= cr_first_q;
      ctrl_second_out <= cr_second_q;
      tone_select_out <= tone_q;
    end
  end

endmodule : mhp_top

/* sim/mhp_top_asserts.sv */
module mhp_top_asserts #(
  parameter int BIT_HALF = 8,
  parameter int BAUD_HALF = 4
) (
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic device_reset, // Reset pin
  input wire logic serial_mode, // Bus choice
  input wire logic cs_n, // Chip select
  input wire logic rd_n, // Read strobe
  input wire logic bus_oe, // Bus drive enable
  input wire logic ser_data_oe, // Serial drive enable
  input wire logic int_n, // Interrupt
  input wire logic clk_out, // Clock output
  input wire logic carrier_present, // Carrier level
  input wire logic receive_bit_clock, // Receive clock
  input wire logic rx_data_out, // Received data
  input wire logic rx_bit_taken, // Receive capture pulse
  input wire logic transmit_bit_clock, // Transmit clock
  input wire logic tx_bit_valid, // Transmit sample pulse
  input wire logic bias_current_set, // Bias pin
  input wire logic power_down, // Power down request
  input wire logic [7:0] ctrl_first_out, // First control register
  input wire logic [7:0] ctrl_second_out // Second control register
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  logic tx_last_q;
  logic [15:0] tx_run_q;
  // Length of the current transmit clock phase; a stuck clock shows as a long run
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_last_q <= 1'b0;
      tx_run_q <= 16'h0000;
    end else begin
      tx_last_q <= transmit_bit_clock;
      tx_run_q <= (transmit_bit_clock != tx_last_q) ? 16'h0000 : tx_run_q + 16'h0001;
    end
  end

  // Lags of 3 to 4 cycles come from the input synchronisers
  a_bus_float_idle: assert property (cs_n [*6] |-> !bus_oe)
    else $error("bus driven without chip select");
  a_bus_read_drive: assert property ((!cs_n && !rd_n && !serial_mode) [*6] |-> bus_oe)
    else $error("bus not driven during read");
  a_ser_oe_idle: assert property ((rd_n || !serial_mode) [*6] |-> !ser_data_oe)
    else $error("serial data driven outside read");
  a_int_release: assert property (device_reset [*4] |=> int_n)
    else $error("interrupt held through reset");
  a_reset_clears: assert property (device_reset [*5] |-> (ctrl_first_out == 8'h00)
    && (ctrl_second_out == 8'h00))
    else $error("registers not cleared by reset");
  a_clk_crystal: assert property (device_reset [*8] |-> clk_out != $past(clk_out))
    else $error("clock output not crystal during reset");
  a_power_down: assert property ($stable(bias_current_set) [*5] |->
    power_down == !bias_current_set)
    else $error("power down does not follow bias pin");
  a_rx_clk_stop: assert property ((!carrier_present) [*6] |-> !receive_bit_clock)
    else $error("receive clock runs without carrier");
  a_rx_data_fall: assert property ($changed(rx_data_out) |-> $fell(receive_bit_clock))
    else $error("received data moved off a falling edge");
  a_rx_take_fall: assert property (rx_bit_taken |-> $fell(receive_bit_clock))
    else $error("receive capture off a falling edge");
  a_tx_valid_rise: assert property (tx_bit_valid |-> $rose(transmit_bit_clock))
    else $error("transmit sample off a rising edge");
  a_tx_clk_runs: assert property (tx_run_q < 4 * BIT_HALF)
    else $error("transmit clock stopped");

  c_bus_read: cover property ($rose(bus_oe));
  c_ser_read: cover property ($rose(ser_data_oe));
  c_int_raise: cover property ($fell(int_n));
endmodule : mhp_top_asserts

bind mhp_top mhp_top_asserts #(.BIT_HALF(BIT_HALF), .BAUD_HALF(BAUD_HALF))
  mhp_top_asserts_i (.*);

/* sim/mhp_host_model.sv */
module mhp_host_model (
  input wire logic clk_sys, // System clock
  input wire logic [7:0] bus_out, // Device bus data
  input wire logic bus_oe, // Device bus enable
  input wire logic ser_data_out, // Device serial data
  input wire logic ser_data_oe, // Device serial enable
  output logic ale, // Address latch strobe
  output logic cs_n, // Chip select
  output logic rd_n, // Read strobe
  output logic wr_n, // Write strobe
  output logic [7:0] bus_in, // Resolved bus level
  output logic [1:0] register_select, // Serial select lines
  output logic ser_data_in, // Resolved serial level
  output logic external_timing_clock, // Serial shift clock
  output logic serial_mode // Bus choice
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv, sdrv, sd, slast;
  logic [7:0] hd, last;
  initial begin
    {ale, drv, sdrv, sd, slast, serial_mode} = 6'h00;
    {cs_n, rd_n, wr_n, external_timing_clock} = 4'hf;
    {hd, last, register_select} = 18'h00000;
  end
  // A released line shows a changing pattern, never a stale level
  always @(posedge clk_sys) begin
    last <= bus_in;
    slast <= ser_data_in;
  end
  assign bus_in = drv ? hd : (bus_oe ? bus_out : ~last);
  assign ser_data_in = ser_data_oe ? ser_data_out : (sdrv ? sd : ~slast);

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : step
  // Address and select go out together; the strobe fall latches both
  task automatic addr(input logic [1:0] s);
    step(1);
    serial_mode <= 1'b0;
    ale <= 1'b1;
    cs_n <= 1'b0;
    drv <= 1'b1;
    hd <= {6'h00, s[0], s[1]};
    step(4);
    ale <= 1'b0;
    step(4);
  endtask : addr
  // Chip select stays low until well after the write strobe rises
  task automatic pwrite(input logic [1:0] s, input logic [7:0] d);
    addr(s);
    hd <= d;
    wr_n <= 1'b0;
    step(5);
    wr_n <= 1'b1;
    step(4);
    drv <= 1'b0;
    cs_n <= 1'b1;
    step(4);
  endtask : pwrite
  task automatic pread(input logic [1:0] s, output logic [7:0] d);
    addr(s);
    drv <= 1'b0;
    rd_n <= 1'b0;
    step(6);
    d = bus_in;
    rd_n <= 1'b1;
    step(5);
    cs_n <= 1'b1;
    step(4);
  endtask : pread
  // Select lines held for the whole serial operation; the clock idles high
  task automatic swrite(input logic [1:0] s, input logic [7:0] d);
    step(1);
    serial_mode <= 1'b1;
    register_select <= s;
    sdrv <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      sd <= d[i];
      step(4);
      external_timing_clock <= 1'b0;
      step(5);
      external_timing_clock <= 1'b1;
      step(1);
    end
    step(4);
    wr_n <= 1'b0;
    step(5);
    wr_n <= 1'b1;
    sdrv <= 1'b0;
    step(5);
  endtask : swrite
  task automatic sread(input logic [1:0] s, output logic [7:0] d);
    step(1);
    serial_mode <= 1'b1;
    register_select <= s;
    rd_n <= 1'b0;
    step(6);
    for (int i = 0; i < 8; i++) begin
      external_timing_clock <= 1'b0;
      step(5);
      external_timing_clock <= 1'b1;
      step(1);
      d[i] = ser_data_in;
      step(3);
    end
    rd_n <= 1'b1;
    step(6);
  endtask : sread
endmodule : mhp_host_model

/* sim/tb_top.sv */
module tb_top;
  import mhp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BH = 8;
  localparam int QH = 4;
  typedef struct {logic [1:0] sel; logic [7:0] wr; logic [7:0] rd;} mhp_row_s;
  // Plain writes and read-backs, with the read-only detect register last
  mhp_row_s rows [4] = '{'{REG_CTRL_FIRST, 8'ha5, 8'ha5}, '{REG_CTRL_SECOND, 8'h02, 8'h02},
    '{REG_TONE, 8'hff, 8'hff}, '{REG_DETECT, 8'hff, 8'h00}};
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic device_reset = 1'b0, carrier_present = 1'b1, rx_bit_in = 1'b0;
  logic tx_data_in = 1'b1, bias_current_set = 1'b1;
  logic [7:0] detect_in = 8'h00;
  logic ale, cs_n, rd_n, wr_n, serial_mode, ser_data_in, ser_data_out, ser_data_oe;
  logic external_timing_clock, bus_oe, int_n, clk_out, receive_bit_clock, rx_data_out;
  logic rx_bit_taken, transmit_bit_clock, tx_bit_valid, power_down, tx_bit_out;
  logic [1:0] register_select;
  logic [7:0] bus_in, bus_out, ctrl_first_out, ctrl_second_out, tone_select_out, rd;
  int error_cnt = 0;
  int samples_checked = 0;
  int n;

  always #2.5 clk_sys = ~clk_sys;
  // Demodulator side offers a fresh bit each time one is taken
  always @(posedge clk_sys) if (rx_bit_taken === 1'b1) rx_bit_in <= ~rx_bit_in;

  mhp_top #(.BIT_HALF(BH), .BAUD_HALF(QH)) mhp_top_i (.*);
  mhp_host_model mhp_host_model_i (.*);

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : tick
  task automatic results();
    $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  // Watchdog sized well past the whole sequence
  initial begin
    tick(20000);
    error_cnt++;
    results();
  end

  initial begin
    tick(4);
    reset_n <= 1'b1;
    tick(4);
    foreach (rows[i]) mhp_host_model_i.pwrite(rows[i].sel, rows[i].wr);
    foreach (rows[i]) begin
      mhp_host_model_i.pread(rows[i].sel, rd);
      check(rd, rows[i].rd);
    end
    check(ctrl_first_out, 8'ha5);
    // Serial write, then read back of the same byte over the serial and the parallel bus
    mhp_host_model_i.swrite(REG_TONE, 8'h3c);
    mhp_host_model_i.sread(REG_TONE, rd);
    check(rd, 8'h3c);
    check(tone_select_out, 8'h3c);
    mhp_host_model_i.pread(REG_TONE, rd);
    check(rd, 8'h3c);
    // Sticky detect raises the interrupt; reading it clears both
    detect_in <= 8'h05;
    tick(1);
    detect_in <= 8'h00;
    tick(3);
    check({7'h00, int_n}, 8'h00);
    mhp_host_model_i.pread(REG_DETECT, rd);
    check(rd, 8'h05);
    check({7'h00, int_n}, 8'h01);
    mhp_host_model_i.pread(REG_DETECT, rd);
    check(rd, 8'h00);
    // Baud clock high phase lasts the shortened half period
    mhp_host_model_i.pwrite(REG_CTRL_SECOND, 8'h80);
    n = 0;
    while (clk_out !== 1'b0 && n < 100) begin
      tick(1);
      n++;
    end
    while (clk_out !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    n = 0;
    while (clk_out === 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    check(8'(n), 8'(QH));
    // Reset pin with a pending interrupt clears the registers and the interrupt
    detect_in <= 8'h01;
    tick(1);
    detect_in <= 8'h00;
    device_reset <= 1'b1;
    tick(10);
    device_reset <= 1'b0;
    tick(4);
    check({7'h00, int_n}, 8'h01);
    check(ctrl_second_out, 8'h00);
    mhp_host_model_i.pread(REG_TONE, rd);
    check(rd, 8'h00);
    bias_current_set <= 1'b0;
    tick(6);
    check({7'h00, power_down}, 8'h01);
    bias_current_set <= 1'b1;
    carrier_present <= 1'b0;
    tick(8);
    check({7'h00, receive_bit_clock}, 8'h00);
    carrier_present <= 1'b1;
    tick(40);
    // Received data moves in the cycle the demodulator bit is taken
    n = 0;
    while (rx_bit_taken !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    check({7'h00, rx_data_out}, {7'h00, rx_bit_in});
    // Synchronous, external timing: a rise of the reference re-phases the clock
    mhp_host_model_i.pwrite(REG_CTRL_SECOND, 8'h01);
    mhp_host_model_i.external_timing_clock <= 1'b0;
    tick(20);
    mhp_host_model_i.external_timing_clock <= 1'b1;
    tick(12);
    check({7'h00, transmit_bit_clock}, 8'h01);
    tick(1);
    check({7'h00, transmit_bit_clock}, 8'h00);
    // Terminal data is taken only at the next rising edge
    tx_data_in <= 1'b0;
    tick(7);
    check({7'h00, tx_bit_out}, 8'h01);
    tick(1);
    check({6'h00, tx_bit_out, tx_bit_valid}, 8'h01);
    tx_data_in <= 1'b1;
    tick(4);
    results();
  end
endmodule : tb_top
